/* msr_top.sv */
// Behaviour
// - Zero retry count skips error recovery
// - Command recovery time bounded by limit, ms
// - Recovery timer runs only in recovery, restarts
// - Limit zero means default FFFF
// - Limit 0001 gives the shortest budget
// - Limit FFFF leaves only per-LBA retry bound
// - Idle-time sequential background scan of whole media
// - Scan starts after 500 ms idle
// - Scan bursts end at the first block end after 800 ms
// - Scan segments of 400 blocks, then check host
// - Scan recovery finishes before host service
// - Log unrecovered sites; recovered logged or reallocated
// - First command after interrupted scan delayed 4 ms
// - Pre-scan turns unscanned writes into write-verify
// - Pre-scan starts scan immediately on idle
// - Jumpers sampled only at power-on
// - Exhausted recovery: continue if scan or read-continuous, else stop
// - Reallocation time not charged to budget
`include "msr_cfg.svh"

module msr_top
  import msr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS   = `MSR_CYC_PER_MS,
  parameter int unsigned LBA_W        = 32,
  parameter logic [31:0] MEDIA_BLOCKS = 32'h0001_0000
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             prescan_jumper,
  input  wire logic             read_continuous_flag,
  input  wire logic             auto_read_reallocate,
  input  wire logic             auto_write_reallocate,
  input  wire logic [7:0]       read_retry_count,
  input  wire logic [7:0]       write_retry_count,
  input  wire logic [15:0]      recovery_time_limit,
  input  wire logic             host_cmd_valid,
  input  wire logic             host_cmd_write,
  input  wire logic [LBA_W-1:0] host_cmd_lba,
  input  wire logic [15:0]      host_cmd_blocks,
  output logic                  host_cmd_ack,
  output logic                  host_cmd_busy,
  output logic                  host_cmd_done,
  output logic                  host_cmd_error,
  output logic [LBA_W-1:0]      host_last_good_lba,
  output logic                  media_req,
  output logic [1:0]            media_op,
  output logic [LBA_W-1:0]      media_lba,
  output logic [7:0]            media_retry_level,
  input  wire logic             media_done,
  input  wire logic             media_err,
  output logic                  realloc_req,
  input  wire logic             realloc_done,
  output logic                  background_media_scan_active,
  output logic [LBA_W-1:0]      scan_ptr,
  output logic                  prescan_active,
  output logic                  log_valid,
  output logic [LBA_W-1:0]      log_lba,
  output logic                  log_unrecovered,
  output logic                  log_reallocated
);

  initial
  begin
    if (LBA_W < 17 || LBA_W > 32)
      $error("LBA_W must be 17..32");
    if (MEDIA_BLOCKS < 32'd2)
      $error("MEDIA_BLOCKS must be at least 2");
  end

  localparam logic [LBA_W-1:0] LAST_LBA = LBA_W'(MEDIA_BLOCKS - 32'd1);

  // --------------------------------------------------------------------------
  // State and storage
  // --------------------------------------------------------------------------
  msr_state_t       state_reg, state_next;
  logic [LBA_W-1:0] cur_lba_reg;
  logic [15:0]      remain_reg;
  logic             cmd_write_reg;
  logic             in_scan_reg;
  logic [7:0]       attempt_reg;
  logic [15:0]      seg_cnt_reg;
  logic [LBA_W-1:0] scan_ptr_reg;
  logic             covered_reg;
  logic             interrupted_reg;
  logic             prescan_strap;
  logic             strap_valid;
  logic [15:0]      rec_ms, idle_ms, burst_ms, resume_ms;

  // Power-on jumper capture
  msr_strap_latch #(.W(1)) u_strap (
    .clock       (clock),
    .rst         (rst),
    .pin         (prescan_jumper),
    .strap       (prescan_strap),
    .strap_valid (strap_valid)
  );

  // --------------------------------------------------------------------------
  // Millisecond timers
  // --------------------------------------------------------------------------
  logic in_rec, cmd_take, scan_go, in_scan_st, idle_run;

  assign in_rec     = (state_reg == MSR_S_REC_REQ) || (state_reg == MSR_S_REC_WAIT);
  assign in_scan_st = (state_reg == MSR_S_SCAN_REQ) || (state_reg == MSR_S_SCAN_WAIT)
                      || in_scan_reg;
  assign idle_run   = (state_reg == MSR_S_IDLE) && !host_cmd_valid && strap_valid;

  // Budget clock: recovery only, cleared per command
  msr_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_rec_t (
    .clock    (clock),
    .rst      (rst),
    .clear    (cmd_take || scan_go),
    .run      (in_rec),
    .ms_count (rec_ms)
  );

  // Continuous idle time
  msr_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_idle_t (
    .clock    (clock),
    .rst      (rst),
    .clear    (!idle_run),
    .run      (idle_run),
    .ms_count (idle_ms)
  );

  // Current scan burst length
  msr_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_burst_t (
    .clock    (clock),
    .rst      (rst),
    .clear    (scan_go),
    .run      (in_scan_st),
    .ms_count (burst_ms)
  );

  // Resume delay after an interrupted scan
  msr_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_resume_t (
    .clock    (clock),
    .rst      (rst),
    .clear    (state_reg != MSR_S_RESUME),
    .run      (state_reg == MSR_S_RESUME),
    .ms_count (resume_ms)
  );

  // --------------------------------------------------------------------------
  // Recovery decisions
  // --------------------------------------------------------------------------
  logic [15:0] limit_eff;
  logic [7:0]  retries;
  logic        budget_over, done_ev, first_wait, first_fail, unrec, recov;
  logic        realloc_en, realloc_go, blk_end, host_stop, prescan_on, wr_verify;

  assign limit_eff   = (recovery_time_limit == `MSR_RTL_ZERO) ? `MSR_RTL_DEFAULT
                       : recovery_time_limit;
  assign budget_over = (limit_eff != `MSR_RTL_DEFAULT) && (rec_ms >= limit_eff);
  assign retries     = (in_scan_reg || !cmd_write_reg) ? read_retry_count
                       : write_retry_count;
  assign first_wait  = (state_reg == MSR_S_XFER_WAIT) || (state_reg == MSR_S_SCAN_WAIT);
  assign done_ev     = media_done && (first_wait || state_reg == MSR_S_REC_WAIT);
  assign first_fail  = first_wait && media_done && media_err;
  assign recov       = (state_reg == MSR_S_REC_WAIT) && media_done && !media_err;
  assign unrec       = (first_fail && retries == `MSR_RETRY_NONE)
                       || ((state_reg == MSR_S_REC_REQ) && budget_over)
                       || ((state_reg == MSR_S_REC_WAIT) && media_done && media_err
                           && (attempt_reg >= retries || budget_over));
  assign realloc_en  = (in_scan_reg || !cmd_write_reg) ? auto_read_reallocate
                       : auto_write_reallocate;
  assign realloc_go  = recov && realloc_en && !read_continuous_flag && !budget_over;
  assign blk_end     = (first_wait && media_done && !media_err)
                       || (recov && !realloc_go)
                       || ((state_reg == MSR_S_REALLOC) && realloc_done)
                       || (unrec && (in_scan_reg || read_continuous_flag));
  assign host_stop   = unrec && !in_scan_reg && !read_continuous_flag;
  assign prescan_on  = strap_valid && prescan_strap && !covered_reg;
  assign wr_verify   = prescan_on && (cur_lba_reg >= scan_ptr_reg);
  assign cmd_take    = (state_reg == MSR_S_IDLE) && host_cmd_valid && strap_valid;
  assign scan_go     = (state_reg == MSR_S_IDLE) && idle_run
                       && (prescan_on || idle_ms >= `MSR_IDLE_MS);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  logic seg_last, burst_over;

  assign seg_last   = (seg_cnt_reg == `MSR_SEG_BLOCKS - 16'd1);
  assign burst_over = (burst_ms >= `MSR_BURST_MS);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      MSR_S_IDLE:
        if (cmd_take)
          state_next = interrupted_reg ? MSR_S_RESUME : MSR_S_XFER_REQ;
        else if (scan_go)
          state_next = MSR_S_SCAN_REQ;
      MSR_S_RESUME:
        if (resume_ms >= `MSR_RESUME_MS)
          state_next = MSR_S_XFER_REQ;
      MSR_S_XFER_REQ:
        state_next = MSR_S_XFER_WAIT;
      MSR_S_SCAN_REQ:
        state_next = MSR_S_SCAN_WAIT;
      MSR_S_XFER_WAIT, MSR_S_SCAN_WAIT, MSR_S_REC_REQ, MSR_S_REC_WAIT, MSR_S_REALLOC:
        if (host_stop)
          state_next = MSR_S_DONE;
        else if (blk_end && !in_scan_reg)
          state_next = (remain_reg == 16'd1) ? MSR_S_DONE : MSR_S_XFER_REQ;
        else if (blk_end)
        begin
          // Host is checked only at segment ends; recovery is already complete
          if ((seg_last && host_cmd_valid) || burst_over)
            state_next = MSR_S_IDLE;
          else
            state_next = MSR_S_SCAN_REQ;
        end
        else if (first_fail)
          state_next = MSR_S_REC_REQ;
        else if (state_reg == MSR_S_REC_REQ)
          state_next = MSR_S_REC_WAIT;
        else if (realloc_go)
          state_next = MSR_S_REALLOC;
        else if ((state_reg == MSR_S_REC_WAIT) && done_ev)
          state_next = MSR_S_REC_REQ;
      MSR_S_DONE:
        state_next = MSR_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= MSR_S_IDLE;
    else
      state_reg <= state_next;
  end

  // --------------------------------------------------------------------------
  // Command and retry tracking
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur_lba_reg   <= '0;
      remain_reg    <= 16'h0000;
      cmd_write_reg <= 1'b0;
      in_scan_reg   <= 1'b0;
      attempt_reg   <= 8'h00;
    end
    else
    begin
      if (cmd_take)
      begin
        cur_lba_reg   <= host_cmd_lba;
        remain_reg    <= (host_cmd_blocks == 16'h0000) ? 16'h0001 : host_cmd_blocks;
        cmd_write_reg <= host_cmd_write;
        in_scan_reg   <= 1'b0;
      end
      else if (scan_go)
      begin
        cmd_write_reg <= 1'b0;
        in_scan_reg   <= 1'b1;
      end
      else if (blk_end && !in_scan_reg)
      begin
        cur_lba_reg <= cur_lba_reg + 1'b1;
        remain_reg  <= remain_reg - 16'h0001;
      end
      if (first_fail)
        attempt_reg <= 8'h01;
      else if ((state_reg == MSR_S_REC_WAIT) && media_done && media_err)
        attempt_reg <= attempt_reg + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Scan progress
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      scan_ptr_reg    <= '0;
      covered_reg     <= 1'b0;
      seg_cnt_reg     <= 16'h0000;
      interrupted_reg <= 1'b0;
    end
    else
    begin
      if (blk_end && in_scan_reg && !host_stop)
      begin
        scan_ptr_reg <= (scan_ptr_reg == LAST_LBA) ? '0 : scan_ptr_reg + 1'b1;
        if (scan_ptr_reg == LAST_LBA)
          covered_reg <= 1'b1;
        seg_cnt_reg <= seg_last ? 16'h0000 : seg_cnt_reg + 16'h0001;
        if (seg_last && host_cmd_valid)
          interrupted_reg <= 1'b1;
      end
      else if ((state_reg == MSR_S_RESUME) && (resume_ms >= `MSR_RESUME_MS))
        interrupted_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Media engine requests
  // --------------------------------------------------------------------------
  logic             media_req_reg, realloc_req_reg;
  logic [1:0]       media_op_reg;
  logic [LBA_W-1:0] media_lba_reg;
  logic [7:0]       retry_lvl_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      media_req_reg   <= 1'b0;
      media_op_reg    <= MSR_OP_READ;
      media_lba_reg   <= '0;
      retry_lvl_reg   <= 8'h00;
      realloc_req_reg <= 1'b0;
    end
    else
    begin
      media_req_reg   <= (state_reg == MSR_S_XFER_REQ) || (state_reg == MSR_S_SCAN_REQ)
                         || ((state_reg == MSR_S_REC_REQ) && !budget_over);
      realloc_req_reg <= realloc_go;
      if (state_reg == MSR_S_XFER_REQ)
      begin
        media_op_reg  <= !cmd_write_reg ? MSR_OP_READ
                         : (wr_verify ? MSR_OP_WRVFY : MSR_OP_WRITE);
        media_lba_reg <= cur_lba_reg;
        retry_lvl_reg <= 8'h00;
      end
      else if (state_reg == MSR_S_SCAN_REQ)
      begin
        media_op_reg  <= MSR_OP_READ;
        media_lba_reg <= scan_ptr_reg;
        retry_lvl_reg <= 8'h00;
      end
      else if (state_reg == MSR_S_REC_REQ)
        retry_lvl_reg <= attempt_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Host status
  // --------------------------------------------------------------------------
  logic             ack_reg, busy_reg, done_reg, error_reg, err_pend_reg;
  logic [LBA_W-1:0] last_good_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_reg       <= 1'b0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      error_reg     <= 1'b0;
      err_pend_reg  <= 1'b0;
      last_good_reg <= '0;
    end
    else
    begin
      ack_reg  <= cmd_take;
      busy_reg <= !in_scan_reg ? (state_next != MSR_S_IDLE) && (state_next != MSR_S_SCAN_REQ)
                  : cmd_take;
      done_reg <= (state_reg == MSR_S_DONE);
      if (cmd_take)
        err_pend_reg <= 1'b0;
      else if (host_stop)
      begin
        err_pend_reg  <= 1'b1;
        last_good_reg <= cur_lba_reg - 1'b1;
      end
      error_reg <= (state_reg == MSR_S_DONE) && err_pend_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Scan defect log and status
  // --------------------------------------------------------------------------
  logic             log_valid_reg, log_unrec_reg, log_realloc_reg;
  logic             scan_act_reg, prescan_reg;
  logic [LBA_W-1:0] log_lba_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      log_valid_reg   <= 1'b0;
      log_unrec_reg   <= 1'b0;
      log_realloc_reg <= 1'b0;
      log_lba_reg     <= '0;
      scan_act_reg    <= 1'b0;
      prescan_reg     <= 1'b0;
    end
    else
    begin
      log_valid_reg <= in_scan_reg && (unrec || recov);
      if (in_scan_reg && (unrec || recov))
      begin
        log_unrec_reg   <= unrec;
        log_realloc_reg <= realloc_go;
        log_lba_reg     <= scan_ptr_reg;
      end
      scan_act_reg <= in_scan_reg && !cmd_take && (state_next != MSR_S_IDLE);
      prescan_reg  <= prescan_on;
    end
  end

  assign host_cmd_ack                 = ack_reg;
  assign host_cmd_busy                = busy_reg;
  assign host_cmd_done                = done_reg;
  assign host_cmd_error               = error_reg;
  assign host_last_good_lba           = last_good_reg;
  assign media_req                    = media_req_reg;
  assign media_op                     = media_op_reg;
  assign media_lba                    = media_lba_reg;
  assign media_retry_level            = retry_lvl_reg;
  assign realloc_req                  = realloc_req_reg;
  assign background_media_scan_active = scan_act_reg;
  assign scan_ptr                     = scan_ptr_reg;
  assign prescan_active               = prescan_reg;
  assign log_valid                    = log_valid_reg;
  assign log_lba                      = log_lba_reg;
  assign log_unrecovered              = log_unrec_reg;
  assign log_reallocated              = log_realloc_reg;

endmodule : msr_top

/* msr_cfg.svh */
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define MSR_CLK_MHZ        250
`define MSR_CYC_PER_MS     (`MSR_CLK_MHZ * 1000)
`define MSR_IDLE_MS        16'd500
`define MSR_BURST_MS       16'd800
`define MSR_RESUME_MS      16'd4

// ----------------------------------------------------------------------------
// Scan geometry and recovery limits
// ----------------------------------------------------------------------------
`define MSR_SEG_BLOCKS     16'd400
`define MSR_RTL_DEFAULT    16'hFFFF
`define MSR_RTL_MIN        16'h0001
`define MSR_RTL_ZERO       16'h0000
`define MSR_RETRY_NONE     8'h00
`define MSR_MS_SAT         16'hFFFF

`endif

/* msr_pkg.sv */
package msr_pkg;

  // --------------------------------------------------------------------------
  // Controller states
  // --------------------------------------------------------------------------
  typedef enum logic [9:0] {
    MSR_S_IDLE      = 10'h001,
    MSR_S_RESUME    = 10'h002,
    MSR_S_XFER_REQ  = 10'h004,
    MSR_S_XFER_WAIT = 10'h008,
    MSR_S_REC_REQ   = 10'h010,
    MSR_S_REC_WAIT  = 10'h020,
    MSR_S_REALLOC   = 10'h040,
    MSR_S_SCAN_REQ  = 10'h080,
    MSR_S_SCAN_WAIT = 10'h100,
    MSR_S_DONE      = 10'h200
  } msr_state_t;

  // Media engine operation codes
  typedef enum logic [1:0] {
    MSR_OP_READ  = 2'h0,
    MSR_OP_WRITE = 2'h1,
    MSR_OP_WRVFY = 2'h2
  } msr_op_t;

endpackage : msr_pkg

/* msr_ms_timer.sv */
`include "msr_cfg.svh"

module msr_ms_timer
  import msr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `MSR_CYC_PER_MS
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        run,
  output logic [15:0]      ms_count
);

  localparam int unsigned PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

  initial
  begin
    if (CYC_PER_MS < 2)
      $error("CYC_PER_MS must be at least 2");
  end

  logic [PW-1:0] pre_reg;
  logic [15:0]   ms_reg;
  logic          wrap;

  assign wrap     = run && (pre_reg == PRE_LAST);
  assign ms_count = ms_reg;

  // Cycle prescaler, runs only while enabled
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pre_reg <= '0;
    else if (clear || wrap)
      pre_reg <= '0;
    else if (run)
      pre_reg <= pre_reg + 1'b1;
  end

  // Saturating millisecond count
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ms_reg <= 16'h0000;
    else if (clear)
      ms_reg <= 16'h0000;
    else if (wrap && ms_reg != `MSR_MS_SAT)
      ms_reg <= ms_reg + 16'h0001;
  end

endmodule : msr_ms_timer

/* msr_strap_latch.sv */
`include "msr_cfg.svh"

module msr_strap_latch
  import msr_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic [W-1:0]      strap,
  output logic              strap_valid
);

  initial
  begin
    if (W < 1)
      $error("W must be at least 1");
  end

  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] strap_reg;
  logic [1:0]   settle_reg;
  logic         valid_reg;

  assign strap       = strap_reg;
  assign strap_valid = valid_reg;

  // Two-stage jumper synchroniser
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Capture once after release, hold until reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      settle_reg <= 2'h0;
      strap_reg  <= '0;
      valid_reg  <= 1'b0;
    end
    else if (!valid_reg)
    begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == 2'h2)
      begin
        strap_reg <= sync2_reg;
        valid_reg <= 1'b1;
      end
    end
  end

endmodule : msr_strap_latch

/* msr_top_assertions.sv */
module msr_top_chk
  import msr_pkg::*;
#(
  parameter int unsigned LBA_W = 32
)
(
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             read_continuous_flag,
  input wire logic [7:0]       read_retry_count,
  input wire logic             host_cmd_ack,
  input wire logic             host_cmd_busy,
  input wire logic             host_cmd_done,
  input wire logic             host_cmd_error,
  input wire logic             media_req,
  input wire logic [1:0]       media_op,
  input wire logic [7:0]       media_retry_level,
  input wire logic             realloc_req,
  input wire logic             background_media_scan_active,
  input wire logic [LBA_W-1:0] scan_ptr,
  input wire logic             prescan_active,
  input wire logic             log_valid,
  input wire logic             log_unrecovered,
  input wire logic             log_reallocated
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_retry_level_bound: assert property (media_req && media_op == MSR_OP_READ
    |-> media_retry_level <= read_retry_count) else $error("retry too high");
  a_error_with_done: assert property (host_cmd_error |-> host_cmd_done)
    else $error("error without done");
  a_realloc_needs_norc: assert property (realloc_req |-> !read_continuous_flag)
    else $error("realloc while continuous");
  a_log_kind_excl: assert property (log_valid && log_unrecovered
    |-> !log_reallocated) else $error("unrec reallocated");
  a_scan_host_excl: assert property (background_media_scan_active
    |-> !host_cmd_busy) else $error("scan while busy");
  a_ack_not_scan: assert property (host_cmd_ack |-> !background_media_scan_active)
    else $error("ack during scan");
  a_wrvfy_in_prescan: assert property (media_req && media_op == MSR_OP_WRVFY
    |-> prescan_active) else $error("stray write-verify");
  a_scan_ptr_step: assert property ($changed(scan_ptr)
    |-> scan_ptr == $past(scan_ptr) + 1'b1 || scan_ptr == '0) else $error("scan skipped");

  c_cmd_error: cover property (host_cmd_error);
  c_scan_start: cover property ($rose(background_media_scan_active));
  c_realloc: cover property (realloc_req);
endmodule : msr_top_chk

bind msr_top msr_top_chk #(.LBA_W(LBA_W)) chk (.*);

/* msr_media_model.sv */
module msr_media_model
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        media_req,
  input  wire logic [31:0] media_lba,
  input  wire logic [7:0]  media_retry_level,
  input  wire logic        realloc_req,
  input  wire logic [31:0] bad_lba,
  input  wire logic [7:0]  bad_tries,
  output logic             media_done,
  output logic             media_err,
  output logic             realloc_done
);
  int wait_cnt, rel_cnt;

  // ----------------
  // Media engine
  // ----------------
  // Five-cycle ops; bad block fails below bad_tries
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wait_cnt <= 0;
      rel_cnt <= 0;
      media_done <= 1'b0;
      media_err <= 1'b0;
      realloc_done <= 1'b0;
    end
    else
    begin
      media_done <= (wait_cnt == 1);
      media_err <= (wait_cnt == 1) ? (media_lba == bad_lba && media_retry_level < bad_tries)
                                   : ~media_err; // Not valid outside done
      wait_cnt <= media_req ? 5 : (wait_cnt > 0 ? wait_cnt - 1 : 0);
      realloc_done <= (rel_cnt == 1);
      rel_cnt <= realloc_req ? 30 : (rel_cnt > 0 ? rel_cnt - 1 : 0);
    end
  end
endmodule : msr_media_model

/* test_media_scan_recovery_control.sv */
module test_media_scan_recovery_control
  import msr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst = 1'b1, pj = 1'b0, cf = 1'b0, arr = 1'b0;
  logic        valid = 1'b0, wr = 1'b0, ack, busy, done, err, mreq, mdone, merr;
  logic        rreq, rdone, scan, pre, lv, lu, lr, cmd_err;
  logic [1:0]  mop, last_op;
  logic [7:0]  rrc = 8'h03, lvl, bt = 8'h00;
  logic [15:0] rtl = 16'h0000, blk = 16'h0001;
  logic [31:0] lba = 32'h0, lgood, mlba, sptr, llba, bad = 32'hFFFF_FFFF;
  int          fails = 0, samples_checked = 0, n_req = 0, n_rel = 0, took, pre_req, c, k;

  always #2 clock = ~clock;

  msr_top #(.CYC_PER_MS(10), .MEDIA_BLOCKS(32'h0000_0200)) DUT (.clock(clock), .rst(rst),
    .prescan_jumper(pj), .read_continuous_flag(cf), .auto_read_reallocate(arr),
    .auto_write_reallocate(1'b0), .read_retry_count(rrc), .write_retry_count(8'h03),
    .recovery_time_limit(rtl), .host_cmd_valid(valid), .host_cmd_write(wr),
    .host_cmd_lba(lba), .host_cmd_blocks(blk), .host_cmd_ack(ack), .host_cmd_busy(busy),
    .host_cmd_done(done), .host_cmd_error(err), .host_last_good_lba(lgood),
    .media_req(mreq), .media_op(mop), .media_lba(mlba), .media_retry_level(lvl),
    .media_done(mdone), .media_err(merr), .realloc_req(rreq), .realloc_done(rdone),
    .background_media_scan_active(scan), .scan_ptr(sptr), .prescan_active(pre),
    .log_valid(lv), .log_lba(llba), .log_unrecovered(lu), .log_reallocated(lr));

  msr_media_model MODEL (.clock(clock), .rst(rst), .media_req(mreq), .media_lba(mlba),
    .media_retry_level(lvl), .realloc_req(rreq), .bad_lba(bad), .bad_tries(bt),
    .media_done(mdone), .media_err(merr), .realloc_done(rdone));

  // Count requests
  always @(posedge clock)
  begin
    if (mreq === 1'b1)
    begin
      n_req++;
      last_op = mop;
    end
    if (rreq === 1'b1)
      n_rel++;
  end

  // ----------------
  // Helpers
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic wait_for(ref logic sig, input int lim, output int cyc);
    cyc = 0;
    while (sig !== 1'b1)
    begin
      @(posedge clock);
      #1;
      cyc++;
      if (cyc > lim)
      begin
        fails++;
        print_verdict;
      end
    end
  endtask : wait_for

  task automatic do_reset(input logic j);
    pj <= j;
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : do_reset

  task automatic host(input logic w, input logic [31:0] a, input logic [15:0] n);
    @(posedge clock);
    wr <= w;
    lba <= a;
    blk <= n;
    valid <= 1'b1;
    wait_for(ack, 30000, c);
    valid <= 1'b0;
    pre_req = n_req;
    n_req = 0;
    wait_for(done, 30000, took);
    cmd_err = err;
  endtask : host

  task automatic set_err(input logic [7:0] r, input logic [7:0] t, input logic [15:0] l);
    @(posedge clock);
    rrc <= r;
    bt <= t;
    rtl <= l;
    bad <= 32'h6;
  endtask : set_err

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_no_retry;
    @(posedge clock);
    pj <= 1'b1;
    repeat (10) @(posedge clock);
    check(pre, 1'b0, "pre");
    set_err(8'h00, 8'h01, 16'h0000);
    host(1'b0, 32'h5, 16'h3);
    check(n_req, 2, "reqs");
    check(cmd_err, 1'b1, "err");
    check(lgood, 32'h5, "good");
  endtask : t_no_retry

  task automatic t_continue_and_recover;
    @(posedge clock);
    cf <= 1'b1;
    host(1'b0, 32'h5, 16'h3);
    check(cmd_err, 1'b0, "err");
    check(n_req, 3, "reqs");
    @(posedge clock);
    cf <= 1'b0;
    arr <= 1'b1;
    n_rel = 0;
    set_err(8'h03, 8'h02, 16'h0000);
    host(1'b0, 32'h5, 16'h3);
    check(n_req, 5, "reqs");
    check(n_rel, 1, "rel");
  endtask : t_continue_and_recover

  task automatic t_limits;
    set_err(8'h03, 8'hFF, 16'h0000);
    host(1'b0, 32'h6, 16'h1);
    check(n_req, 4, "reqs");
    check(cmd_err, 1'b1, "err");
    set_err(8'hC8, 8'hFF, 16'h0001);
    host(1'b0, 32'h6, 16'h1);
    k = n_req;
    check(cmd_err, 1'b1, "err");
    check(n_req < 6, 1'b1, "cut");
    host(1'b0, 32'h6, 16'h1);
    check(n_req, k, "again");
  endtask : t_limits

  task automatic t_scan;
    set_err(8'h03, 8'h02, 16'h0000);
    wait_for(scan, 6000, c);
    n_req = 0;
    check(c >= 4990 && c <= 5010, 1'b1, "idle");
    host(1'b0, 32'h10, 16'h1);
    check(pre_req, 402, "seg");
    check(llba, 32'h6, "log");
    check(lr, 1'b1, "lre");
    check(took >= 40, 1'b1, "resume");
  endtask : t_scan

  task automatic t_prescan;
    do_reset(1'b1);
    wait_for(scan, 20, c);
    check(pre, 1'b1, "pre");
    host(1'b1, 32'h1F0, 16'h1);
    check(last_op, MSR_OP_WRVFY, "op");
  endtask : t_prescan

  initial
  begin
    do_reset(1'b0);
    t_no_retry;
    t_continue_and_recover;
    t_limits;
    t_scan;
    t_prescan;
    print_verdict;
  end
endmodule : test_media_scan_recovery_control
